// ### src/epc_top.sv
/*
 Programmable-memory program control: loader-mode entry at reset, loader
 function select, indicator pins, control register with interlock, and the
 programming-voltage enable. Registers sit on AHB-Lite.
 Assumes pins are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
module epc_top
   import epc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Mode pins
   input wire logic irq_test_mode_voltage,
   input wire logic capture_input_pin,
   input wire logic loader_select_hi,
   input wire logic loader_select_mid,
   input wire logic loader_select_lo,
   // Indicators and array control
   output logic program_indicator_pin,
   output logic verify_indicator_pin,
   output logic eprom_program_control_voltage_en,
   output logic read_blocked,
   output logic loader_rom_hit
);
   // --------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------
   logic [4:0] pin_s1_ff;
   logic [4:0] pin_s2_ff;
   wire [4:0] pins = {capture_input_pin, irq_test_mode_voltage, loader_select_hi,
                      loader_select_mid, loader_select_lo};

   always_ff @(posedge clk)
   begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
   end

   wire [2:0] sel_pins = pin_s2_ff[2:0];
   wire irq_tst = pin_s2_ff[3];
   wire cap_hi = pin_s2_ff[4];

   // --------------------------------------------------
   // Mode capture at reset release
   // --------------------------------------------------
   logic in_reset_ff;
   logic loader_ff;
   logic [2:0] func_ff;

   always_ff @(posedge clk)
   begin
      in_reset_ff <= srst;
      if (srst)
      begin
         loader_ff <= 1'b0;
         func_ff <= 3'h0;
      end
      else if (in_reset_ff)
      begin
         loader_ff <= irq_tst && cap_hi;
         func_ff <= sel_pins;
      end
   end

   wire fn_pgm = loader_ff && (func_ff == EPC_FN_PGM_VERIFY);
   wire fn_ver = loader_ff && (func_ff == EPC_FN_VERIFY);

   // --------------------------------------------------
   // AHB-Lite address phase
   // --------------------------------------------------
   logic wr_ph_ff;
   logic rd_ph_ff;
   logic [31:0] addr_ff;
   wire take = hsel && hready && htrans[1];

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_ph_ff <= 1'b0;
         rd_ph_ff <= 1'b0;
         addr_ff <= 32'h0000_0000;
      end
      else if (hready)
      begin
         wr_ph_ff <= take && hwrite;
         rd_ph_ff <= take && !hwrite;
         addr_ff <= haddr;
      end
   end

   wire wr_ctrl = wr_ph_ff && (addr_ff == EPC_CTRL_ADDR);
   wire wr_wa = wr_ph_ff && (addr_ff == EPC_WADDR_ADDR);
   wire wr_wd = wr_ph_ff && (addr_ff == EPC_WDATA_ADDR);
   wire wr_ra = wr_ph_ff && (addr_ff == EPC_RADDR_ADDR);

   // --------------------------------------------------
   // Control register and memory-write port
   // --------------------------------------------------
   logic latch_ff;
   logic pgm_ff;
   logic [EPC_AW-1:0] waddr_ff;
   logic [EPC_AW-1:0] raddr_ff;
   logic mem_wr_ff;
   logic [7:0] wdata_ff;
   wire nxt_latch = hwdata[EPC_LATCH_BIT];
   // Program bit needs latch already set before this write
   wire nxt_pgm = hwdata[EPC_PGM_BIT] && latch_ff;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         latch_ff <= EPC_CTRL_RESET[EPC_LATCH_BIT];
         pgm_ff <= EPC_CTRL_RESET[EPC_PGM_BIT];
      end
      else if (wr_ctrl)
      begin
         latch_ff <= nxt_latch;
         pgm_ff <= nxt_pgm;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         waddr_ff <= '0;
         raddr_ff <= '0;
         wdata_ff <= 8'h00;
         mem_wr_ff <= 1'b0;
      end
      else
      begin
         mem_wr_ff <= wr_wd;
         if (wr_wa)
            waddr_ff <= hwdata[EPC_AW-1:0];
         if (wr_ra)
            raddr_ff <= hwdata[EPC_AW-1:0];
         if (wr_wd)
            wdata_ff <= hwdata[7:0];
      end
   end

   epc_mem_if mif ();
   assign mif.latch = latch_ff;
   assign mif.wr = mem_wr_ff;
   assign mif.waddr = waddr_ff;
   assign mif.wdata = wdata_ff;

   epc_path u_path
   (
      .clk(clk),
      .srst(srst),
      .m(mif)
   );

   // --------------------------------------------------
   // Read mux and outputs
   // --------------------------------------------------
   wire [31:0] ctrl_rd = {29'h0, latch_ff, 1'b0, pgm_ff};
   wire [31:0] stat_rd = {27'h0, cap_hi, func_ff, loader_ff};
   wire [31:0] rd_mux =
      (addr_ff == EPC_CTRL_ADDR) ? ctrl_rd :
      (addr_ff == EPC_STAT_ADDR) ? stat_rd :
      (addr_ff == EPC_LADDR_ADDR) ? {18'h0, mif.captured, 13'h0} | {18'h0, mif.cap_addr} :
      (addr_ff == EPC_LDATA_ADDR) ? {24'h0, mif.cap_data} :
      (addr_ff == EPC_WADDR_ADDR) ? {18'h0, waddr_ff} :
      (addr_ff == EPC_WDATA_ADDR) ? {24'h0, wdata_ff} :
      (addr_ff == EPC_RADDR_ADDR) ? {18'h0, raddr_ff} :
      32'h0000_0000;

   always_ff @(posedge clk)
   begin
      if (srst)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= 32'h0000_0000;
      else if (rd_ph_ff)
         hrdata <= rd_mux;
   end

   logic rd_done_ff;
   assign hreadyout = !rd_ph_ff || rd_done_ff;
   always_ff @(posedge clk)
   begin
      if (srst)
         rd_done_ff <= 1'b0;
      else
         rd_done_ff <= rd_ph_ff && !rd_done_ff;
   end
   assign hresp = 1'b0;

   assign eprom_program_control_voltage_en = pgm_ff;
   assign read_blocked = mif.rd_block;
   assign loader_rom_hit = loader_ff && (raddr_ff >= EPC_LOADER_LO)
                           && (raddr_ff <= EPC_LOADER_HI);
   assign program_indicator_pin = fn_pgm && pgm_ff;
   assign verify_indicator_pin = fn_ver || (fn_pgm && latch_ff && !pgm_ff);
endmodule

// ### src/epc_pkg.sv
/*
 Shared constants for the programmable-memory program control block.
 Assumes a 32-bit AHB-Lite register bus and a 100 MHz clock.
*/
package epc_pkg;
   // --------------------------------------------------
   // Register map
   // --------------------------------------------------
   localparam logic [31:0] EPC_CTRL_ADDR = 32'h0000_0000;
   localparam logic [31:0] EPC_STAT_ADDR = 32'h0000_0004;
   localparam logic [31:0] EPC_LADDR_ADDR = 32'h0000_0008;
   localparam logic [31:0] EPC_LDATA_ADDR = 32'h0000_000c;
   localparam logic [31:0] EPC_WADDR_ADDR = 32'h0000_0010;
   localparam logic [31:0] EPC_WDATA_ADDR = 32'h0000_0014;
   localparam logic [31:0] EPC_RADDR_ADDR = 32'h0000_0018;
   localparam logic [31:0] EPC_RDATA_ADDR = 32'h0000_001c;
   localparam int EPC_AW = 14;
   // --------------------------------------------------
   // Field layout
   // --------------------------------------------------
   localparam int EPC_PGM_BIT = 0;
   localparam int EPC_LATCH_BIT = 2;
   localparam int EPC_ST_LOADER = 0;
   localparam int EPC_ST_FUNC_LO = 1;
   localparam int EPC_ST_CAP = 4;
   localparam logic [7:0] EPC_CTRL_RESET = 8'h00;
   // --------------------------------------------------
   // Loader region and functions
   // --------------------------------------------------
   localparam logic [EPC_AW-1:0] EPC_LOADER_LO = 14'h3f00;
   localparam logic [EPC_AW-1:0] EPC_LOADER_HI = 14'h3fef;
   typedef enum logic [2:0]
   {
      EPC_FN_PGM_VERIFY = 3'h0,
      EPC_FN_VERIFY = 3'h1,
      EPC_FN_RAM_EXEC = 3'h2
   } epc_fn_t;
endpackage

// ### src/epc_mem_if.sv
/*
 Interface between the control block and its memory-path steering unit.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface epc_mem_if;
   logic latch;
   logic wr;
   logic [13:0] waddr;
   logic [7:0] wdata;
   logic captured;
   logic [13:0] cap_addr;
   logic [7:0] cap_data;
   logic rd_block;
   modport ctrl (output latch, wr, waddr, wdata, input captured, cap_addr, cap_data, rd_block);
   modport path (input latch, wr, waddr, wdata, output captured, cap_addr, cap_data, rd_block);
endinterface

// ### src/epc_path.sv
/*
 Memory-path steering: captures address and data of the write that follows
 a latch request, and blocks ordinary reads while latched.
 Assumes writes arrive as one-cycle strobes on the same clock.
*/
`timescale 1ns/10ps
module epc_path
   import epc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Control side
   epc_mem_if.path m
);
   logic captured_ff;
   logic [EPC_AW-1:0] cap_addr_ff;
   logic [7:0] cap_data_ff;
   wire take = m.latch && m.wr && !captured_ff;

   always_ff @(posedge clk)
   begin
      if (srst || !m.latch)
      begin
         captured_ff <= 1'b0;
         cap_addr_ff <= '0;
         cap_data_ff <= 8'h00;
      end
      else if (take)
      begin
         captured_ff <= 1'b1;
         cap_addr_ff <= m.waddr;
         cap_data_ff <= m.wdata;
      end
   end

   assign m.captured = captured_ff;
   assign m.cap_addr = cap_addr_ff;
   assign m.cap_data = cap_data_ff;
   assign m.rd_block = m.latch;
endmodule

// ### tb/epc_top_properties.sv
/*
 Checker for the program control block, bound to its top module.
 Assumes single-word AHB-Lite transfers and the zero-wait write timing.
*/
`timescale 1ns/10ps
module epc_top_properties
   import epc_pkg::*;
(
   // Clock, reset and bus
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   // Watched outputs
   input wire logic eprom_program_control_voltage_en,
   input wire logic read_blocked,
   input wire logic program_indicator_pin,
   input wire logic loader_rom_hit
);
   logic ctl_ff;
   logic ra_wr_ff;
   logic [13:0] ra_ff;
   wire take = hsel && hready && htrans[1];
   wire wc = ctl_ff && hready;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctl_ff <= 1'b0;
         ra_wr_ff <= 1'b0;
         ra_ff <= 14'h0000;
      end
      else if (hready)
      begin
         ctl_ff <= take && hwrite && haddr == EPC_CTRL_ADDR;
         ra_wr_ff <= take && hwrite && haddr == EPC_RADDR_ADDR;
         if (ra_wr_ff)
            ra_ff <= hwdata[13:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_latch_follows_write: assert property (wc |=> read_blocked == $past(hwdata[2]))
      else $error("latch bit not written");
   a_pgm_needs_latch: assert property (eprom_program_control_voltage_en |-> read_blocked)
      else $error("voltage on without latch");
   a_pgm_rise_latched: assert property ($rose(eprom_program_control_voltage_en) |-> $past(read_blocked, 2))
      else $error("program bit set without earlier latch");
   a_both_keep_off: assert property (wc && hwdata[0] && !read_blocked |=> !eprom_program_control_voltage_en [*2])
      else $error("program bit set with latch in one write");
   a_pgm_set_volt: assert property (wc && hwdata[0] && hwdata[2] && read_blocked
      |-> ##[1:2] eprom_program_control_voltage_en)
      else $error("voltage not applied");
   a_pgm_clr_volt: assert property (wc && !hwdata[0] |-> ##[1:2] !eprom_program_control_voltage_en)
      else $error("voltage not withheld");
   a_program_indicator_latched: assert property (program_indicator_pin |-> read_blocked)
      else $error("program indicator without latch");
   a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_rom_hit_range: assert property (loader_rom_hit && $stable(ra_ff)
      |-> ra_ff >= EPC_LOADER_LO && ra_ff <= EPC_LOADER_HI)
      else $error("loader region hit out of range");
   c_volt: cover property (eprom_program_control_voltage_en);
   c_rom_hit: cover property (loader_rom_hit);
   c_both_bits: cover property (wc && hwdata[0] && !read_blocked);
endmodule

bind epc_top epc_top_properties u_prop (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .eprom_program_control_voltage_en(eprom_program_control_voltage_en), .read_blocked(read_blocked),
   .program_indicator_pin(program_indicator_pin), .loader_rom_hit(loader_rom_hit));

// ### tb/epc_code_src.sv
/*
 Model of the external code source feeding the loader.
 Assumes a byte is asked for by its target address.
*/
`timescale 1ns/10ps
module epc_code_src
(
   // Target address and code byte
   input wire logic [13:0] addr,
   output logic [7:0] data
);
   assign data = addr[7:0] ^ {2'h0, addr[13:8]} ^ 8'h5a;
endmodule

// ### tb/eprom_program_control_tb.sv
/*
 Self-checking bench for the program control block.
 Assumes the code source model and the bound checker.
*/
`timescale 1ns/10ps
module eprom_program_control_tb
   import epc_pkg::*;
;
   logic clk, srst, hsel, hwrite, irq, cap;
   logic [1:0] htrans;
   logic [2:0] sel;
   logic [13:0] a;
   logic [31:0] haddr, hwdata, rd;
   wire [31:0] hrdata;
   wire hreadyout, led_p, led_v, volt, blk, hit, resp;
   wire [7:0] src_data;
   int err_count, compares;
   logic [13:0] ta [5];
   epc_top DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(resp), .irq_test_mode_voltage(irq), .capture_input_pin(cap),
      .loader_select_hi(sel[2]), .loader_select_mid(sel[1]), .loader_select_lo(sel[0]),
      .program_indicator_pin(led_p), .verify_indicator_pin(led_v), .eprom_program_control_voltage_en(volt),
      .read_blocked(blk), .loader_rom_hit(hit));
   epc_code_src u_src (.addr(a), .data(src_data));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #100000;
      err_count++;
      close_out;
   end
   function logic [7:0] code_byte(input logic [13:0] x);
      return x[7:0] ^ {2'h0, x[13:8]} ^ 8'h5a;
   endfunction
   task close_out;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wait_rdy;
      @(posedge clk);
      while (hreadyout !== 1'b1)
         @(posedge clk);
      rd = hrdata;
   endtask
   task ahb(input logic w, input logic [31:0] ad, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
   endtask
   task rst(input logic i, input logic c, input logic [2:0] s);
      @(posedge clk);
      srst <= 1'b1;
      irq <= i;
      cap <= c;
      sel <= s;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
   endtask
   initial
   begin
      {srst, hsel, hwrite, irq, cap} = 5'h10;
      {htrans, sel, a, haddr, hwdata} = '0;
      void'($urandom(32'h6c01));
      for (int f = 0; f < 3; f++)
      begin
         rst(1'b1, 1'b1, f[2:0]);
         ahb(1'b0, EPC_STAT_ADDR, 32'h0);
         chk(rd & 32'hf, {28'h0, f[2:0], 1'b1}, "status");
         chk({30'h0, led_p, led_v}, {31'h0, f == 1}, "indicators");
      end
      rst(1'b1, 1'b0, 3'h0);
      ahb(1'b0, EPC_STAT_ADDR, 32'h0);
      chk(rd & 32'h1, 32'h0, "user mode");
      $display("test mode entry done");
      rst(1'b1, 1'b1, 3'h0);
      ahb(1'b1, EPC_CTRL_ADDR, 32'h5);
      ahb(1'b0, EPC_CTRL_ADDR, 32'h0);
      chk(rd, 32'h4, "ctrl both bits");
      chk({31'h0, led_v}, 32'h1, "verify led");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h5);
      ahb(1'b0, EPC_CTRL_ADDR, 32'h0);
      chk(rd, 32'h5, "ctrl readback");
      chk({30'h0, volt, led_p}, 32'h3, "voltage on");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h4);
      ahb(1'b0, EPC_CTRL_ADDR, 32'h0);
      chk({31'h0, volt}, 32'h0, "voltage off");
      ahb(1'b1, EPC_CTRL_ADDR, 32'h0);
      ahb(1'b0, EPC_CTRL_ADDR, 32'h0);
      chk({31'h0, blk}, 32'h0, "read path");
      $display("test interlock done");
      repeat (4)
      begin
         a = 14'($urandom) & 14'h1fff;
         ahb(1'b1, EPC_CTRL_ADDR, 32'h4);
         ahb(1'b1, EPC_WADDR_ADDR, {18'h0, a});
         ahb(1'b1, EPC_WDATA_ADDR, {24'h0, src_data});
         ahb(1'b1, EPC_WDATA_ADDR, {24'h0, ~src_data});
         ahb(1'b0, EPC_LDATA_ADDR, 32'h0);
         chk(rd, {24'h0, code_byte(a)}, "captured data");
         ahb(1'b0, EPC_LADDR_ADDR, 32'h0);
         chk(rd, {18'h0, a | 14'h2000}, "captured address");
         chk({31'h0, blk}, 32'h1, "reads blocked");
         ahb(1'b1, EPC_CTRL_ADDR, 32'h0);
         ahb(1'b0, EPC_LADDR_ADDR, 32'h0);
         chk(rd & 32'h2000, 32'h0, "capture cleared");
      end
      $display("test capture done");
      ta = '{14'h3eff, 14'h3f00, 14'h3fef, 14'h3ff0, 14'h3f00 + 14'($urandom % 32'hf0)};
      foreach (ta[i])
      begin
         ahb(1'b1, EPC_RADDR_ADDR, {18'h0, ta[i]});
         ahb(1'b0, 32'h40, 32'h0);
         chk(rd, 32'h0, "unmapped read");
         chk({31'h0, resp}, 32'h0, "response");
         chk({31'h0, hit}, {31'h0, ta[i] >= 14'h3f00 && ta[i] <= 14'h3fef}, "rom hit");
      end
      $display("test loader region done");
      close_out;
   end
endmodule
